// ---- src/trig_sel_pkg.sv ----
// Package for the sequencer 0/1 trigger selection block.
// Assumes a 32-bit APB master on pclk and trigger sources that are synchronous to pclk, except the external pin, which is asynchronous.
package trig_sel_pkg;

	// Register map
	localparam logic [11:0] SEQ_TRIG_SEL_OFS    = 12'h014;
	localparam logic [11:0] TRIG_STATUS_OFS     = 12'h018;
	localparam logic [31:0] SEQ_TRIG_SEL_RESET  = 32'h0000_0000;

	// Field positions
	localparam int          SEQ0_SEL_LSB        = 0;
	localparam int          SEQ1_SEL_LSB        = 4;
	localparam int          SEL_WIDTH           = 4;

	// Selection codes
	localparam logic [3:0]  SEL_PROCESSOR       = 4'h0;
	localparam logic [3:0]  SEL_COMPARATOR0     = 4'h1;
	localparam logic [3:0]  SEL_EXT_PIN         = 4'h4;
	localparam logic [3:0]  SEL_TIMER           = 4'h5;
	localparam logic [3:0]  SEL_PWM_GEN0        = 4'h6;
	localparam logic [3:0]  SEL_PWM_GEN1        = 4'h7;
	localparam logic [3:0]  SEL_PWM_GEN2        = 4'h8;
	localparam logic [3:0]  SEL_ALWAYS          = 4'hf;

	// Trigger events from the surrounding logic, one-cycle pulses
	typedef struct packed {
		logic       comparator0;
		logic       timer;
		logic       timer_output_trigger_enable;
		logic       pwm_gen0;
		logic       pwm_gen1;
		logic       pwm_gen2;
	} trig_src_type;

	// Whole state of the block
	typedef struct packed {
		logic [3:0]  seq0_trigger_sel;
		logic [3:0]  seq1_trigger_sel;
		logic [1:0]  start;
		logic [1:0]  seen;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic        ext_meta;
		logic        ext_sync;
		logic        ext_prev;
	} state_type;

endpackage : trig_sel_pkg

// ---- src/adc_trigger_select.sv ----
// Trigger selection for sample sequencers zero and one, with an APB register slave.
// Assumes trigger sources pulse for one pclk cycle, except the pin, which is asynchronous.
`timescale 1ns/10ps

module adc_trigger_select (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic                           pready,
	output logic [31:0]                    prdata,
	output logic                           pslverr,
	input  wire logic                      processor_start0,
	input  wire logic                      processor_start1,
	input  wire logic                      external_trigger_pin,
	input  wire trig_sel_pkg::trig_src_type trig_src,
	output logic                           sample_sequencer_zero_start,
	output logic                           sample_sequencer_one_start
);
	import trig_sel_pkg::*;

	state_type       state_r;
	state_type       state_nxt;
	logic            ext_pulse;
	logic [1:0][3:0] field_sel;
	logic [1:0]      proc_go;
	logic [1:0]      hit;

	////////////////////////////////////////////////////////////////////////////
	// Trigger decode for one selection field
	function automatic logic trig_hit(input logic [3:0] sel, input logic proc_go,
		input logic pin_go, input trig_src_type s);
		logic hit;
		hit = 1'b0;
		case (sel)
			SEL_PROCESSOR:   hit = proc_go;
			SEL_COMPARATOR0: hit = s.comparator0;
			SEL_EXT_PIN:     hit = pin_go;
			SEL_TIMER:       hit = s.timer & s.timer_output_trigger_enable;
			SEL_PWM_GEN0:    hit = s.pwm_gen0;
			SEL_PWM_GEN1:    hit = s.pwm_gen1;
			SEL_PWM_GEN2:    hit = s.pwm_gen2;
			SEL_ALWAYS:      hit = 1'b1;
			default:         hit = 1'b0;
		endcase
		return hit;
	endfunction : trig_hit

	////////////////////////////////////////////////////////////////////////////
	// Rising edge of the synchronised pin; its previous level is kept in the state
	assign ext_pulse = state_r.ext_sync & ~state_r.ext_prev;

	////////////////////////////////////////////////////////////////////////////
	// Per-sequencer decode and its checks
	assign field_sel[0] = state_r.seq0_trigger_sel;
	assign field_sel[1] = state_r.seq1_trigger_sel;
	assign proc_go[0]   = processor_start0;
	assign proc_go[1]   = processor_start1;

	for (genvar i = 0; i < 2; i++) begin : g_seq
		// One decoder per sequencer, so neither field can steer the other
		assign hit[i] = trig_hit(field_sel[i], proc_go[i], ext_pulse, trig_src);

		a_proc_starts: assert property (@(posedge pclk) disable iff (!presetn)
			(field_sel[i] == SEL_PROCESSOR && proc_go[i]) |=> state_r.start[i])
			else $error("processor start missed");
		a_cmp_starts: assert property (@(posedge pclk) disable iff (!presetn)
			(field_sel[i] == SEL_COMPARATOR0 && trig_src.comparator0) |=> state_r.start[i])
			else $error("comparator start missed");
		a_pin_starts: assert property (@(posedge pclk) disable iff (!presetn)
			(field_sel[i] == SEL_EXT_PIN && $rose(state_r.ext_sync)) |=> state_r.start[i])
			else $error("pin start missed");
		a_timer_starts: assert property (@(posedge pclk) disable iff (!presetn)
			(field_sel[i] == SEL_TIMER && trig_src.timer &&
			trig_src.timer_output_trigger_enable) |=> state_r.start[i])
			else $error("enabled timer start missed");
		a_timer_gated: assert property (@(posedge pclk) disable iff (!presetn)
			(field_sel[i] == SEL_TIMER && !trig_src.timer_output_trigger_enable)
			|=> !state_r.start[i]) else $error("timer start without enable");
		a_pwm0_starts: assert property (@(posedge pclk) disable iff (!presetn)
			(field_sel[i] == SEL_PWM_GEN0 && trig_src.pwm_gen0) |=> state_r.start[i])
			else $error("pwm gen0 start missed");
		a_pwm1_starts: assert property (@(posedge pclk) disable iff (!presetn)
			(field_sel[i] == SEL_PWM_GEN1 && trig_src.pwm_gen1) |=> state_r.start[i])
			else $error("pwm gen1 start missed");
		a_pwm2_starts: assert property (@(posedge pclk) disable iff (!presetn)
			(field_sel[i] == SEL_PWM_GEN2 && trig_src.pwm_gen2) |=> state_r.start[i])
			else $error("pwm gen2 start missed");
		a_always_starts: assert property (@(posedge pclk) disable iff (!presetn)
			(field_sel[i] == SEL_ALWAYS) |=> state_r.start[i])
			else $error("continuous start missed");
		a_reserved_idle: assert property (@(posedge pclk) disable iff (!presetn)
			(field_sel[i] inside {4'h2, 4'h3, [4'h9:4'he]}) |=> !state_r.start[i])
			else $error("reserved code started");
		a_no_stray_start: assert property (@(posedge pclk) disable iff (!presetn)
			(!(proc_go[i] || trig_src.comparator0 || $rose(state_r.ext_sync) ||
			trig_src.timer || trig_src.pwm_gen0 || trig_src.pwm_gen1 ||
			trig_src.pwm_gen2) && field_sel[i] != SEL_ALWAYS) |=> !state_r.start[i])
			else $error("start without an event");
		a_seen_sticks: assert property (@(posedge pclk) disable iff (!presetn)
			state_r.start[i] |-> state_r.seen[i])
			else $error("start not recorded");
		a_seen_clear: assert property (@(posedge pclk) disable iff (!presetn)
			(psel && penable && pready && pwrite && pstrb[0] && paddr == TRIG_STATUS_OFS &&
			pwdata[i] && !hit[i]) |=> !state_r.seen[i])
			else $error("start record not cleared");
	end : g_seq

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic setup;
		logic access;
		setup  = psel & ~penable;
		access = psel & penable;
		state_nxt = state_r;
		state_nxt.ext_meta = external_trigger_pin;
		state_nxt.ext_sync = state_r.ext_meta;
		state_nxt.pready   = setup;
		state_nxt.pslverr  = 1'b0;
		state_nxt.prdata   = 32'h0000_0000;

		state_nxt.ext_prev = state_r.ext_sync;
		// Each sequencer decoded from its own field
		state_nxt.start    = hit;
		// Sticky record of starts, cleared by writing one; a new start wins
		state_nxt.seen = state_r.seen | state_nxt.start;

		if (setup) begin
			if (paddr == SEQ_TRIG_SEL_OFS) begin
				state_nxt.prdata[SEQ0_SEL_LSB +: SEL_WIDTH] = state_r.seq0_trigger_sel;
				state_nxt.prdata[SEQ1_SEL_LSB +: SEL_WIDTH] = state_r.seq1_trigger_sel;
			end else if (paddr == TRIG_STATUS_OFS) begin
				state_nxt.prdata[1:0] = state_r.seen;
			end else begin
				state_nxt.pslverr = 1'b1;
			end
		end
		// Writes take effect at the completing edge
		if (access && state_r.pready && pwrite) begin
			if (paddr == SEQ_TRIG_SEL_OFS && pstrb[0]) begin
				state_nxt.seq0_trigger_sel = pwdata[SEQ0_SEL_LSB +: SEL_WIDTH];
				state_nxt.seq1_trigger_sel = pwdata[SEQ1_SEL_LSB +: SEL_WIDTH];
			end else if (paddr == TRIG_STATUS_OFS && pstrb[0]) begin
				state_nxt.seen = (state_r.seen & ~pwdata[1:0]) | state_nxt.start;
			end
		end
		if (access && state_r.pready) begin
			state_nxt.pready  = 1'b0;
		end
		if (!access) begin
			state_nxt.pslverr = state_nxt.pslverr & setup;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= '0;
			state_r.seq0_trigger_sel <= SEQ_TRIG_SEL_RESET[SEQ0_SEL_LSB +: SEL_WIDTH];
			state_r.seq1_trigger_sel <= SEQ_TRIG_SEL_RESET[SEQ1_SEL_LSB +: SEL_WIDTH];
		end else begin
			state_r <= state_nxt;
		end
	end

	assign pready                      = state_r.pready;
	assign prdata                      = state_r.prdata;
	assign pslverr                     = state_r.pslverr;
	assign sample_sequencer_zero_start = state_r.start[0];
	assign sample_sequencer_one_start  = state_r.start[1];

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_timer_gate_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r.seq0_trigger_sel == SEL_TIMER && !(trig_src.timer &&
		trig_src.timer_output_trigger_enable)) |=> !sample_sequencer_zero_start)
		else $error("timer trigger passed without enable");
	a_pwm0_start_one: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r.seq1_trigger_sel == SEL_PWM_GEN0 && trig_src.pwm_gen0)
		|=> sample_sequencer_one_start) else $error("pwm gen0 missed");
	a_pwm1_start_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r.seq0_trigger_sel == SEL_PWM_GEN1 && trig_src.pwm_gen1)
		|=> sample_sequencer_zero_start) else $error("pwm gen1 missed");
	a_pwm2_start_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r.seq0_trigger_sel == SEL_PWM_GEN2) |=>
		(sample_sequencer_zero_start == $past(trig_src.pwm_gen2)))
		else $error("pwm gen2 mismatch");
	a_always_runs: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r.seq1_trigger_sel == SEL_ALWAYS)[*2] |=> sample_sequencer_one_start)
		else $error("continuous mode idle");
	a_reserved_silent: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r.seq0_trigger_sel inside {4'h2, 4'h3, [4'h9:4'he]})
		|=> !sample_sequencer_zero_start) else $error("reserved code started");
	a_write_field_one: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pwrite && pstrb[0] && paddr == SEQ_TRIG_SEL_OFS)
		|=> (state_r.seq1_trigger_sel == $past(pwdata[7:4]))) else $error("field one write");
	a_write_field_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pwrite && pstrb[0] && paddr == SEQ_TRIG_SEL_OFS)
		|=> (state_r.seq0_trigger_sel == $past(pwdata[3:0]))) else $error("field zero write");
	a_proc_start_indep: assert property (@(posedge pclk) disable iff (!presetn)
		(state_r.seq1_trigger_sel == SEL_PROCESSOR && processor_start1)
		|=> sample_sequencer_one_start) else $error("processor start lost");

	// Register bus timing and access
	a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready) else $error("no ready after setup");
	a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && penable) |=> !pready) else $error("ready held too long");
	a_idle_data_zero: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> (prdata == 32'h0000_0000 && !pslverr))
		else $error("read data outside access");
	a_strobe_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pwrite && !pstrb[0]) |=>
		($stable(state_r.seq0_trigger_sel) && $stable(state_r.seq1_trigger_sel)))
		else $error("write without strobe landed");
	a_other_write_kept: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready && pwrite && paddr != SEQ_TRIG_SEL_OFS) |=>
		($stable(state_r.seq0_trigger_sel) && $stable(state_r.seq1_trigger_sel)))
		else $error("fields changed by other address");
	a_read_fields: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && paddr == SEQ_TRIG_SEL_OFS) |=>
		(prdata == {24'h00_0000, state_r.seq1_trigger_sel, state_r.seq0_trigger_sel}))
		else $error("field read data wrong");
	a_read_status: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && paddr == TRIG_STATUS_OFS) |=>
		(prdata == {30'h0000_0000, $past(state_r.seen)}))
		else $error("status read data wrong");

endmodule : adc_trigger_select

// ---- testbench/trig_source_model.sv ----
// Model of the timer, PWM, comparator, pin and software trigger sources.
// Assumes fire and go are driven on pclk rising edges; one request fires one source, except code 0, which fires both processor starts.
`timescale 1ns/10ps
module trig_source_model
	import trig_sel_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic [3:0] fire,
	input  wire logic       go,
	output trig_src_type    trig_src,
	output logic            pin,
	output logic            proc0,
	output logic            proc1
);
	logic [1:0] hold;
	always @(posedge pclk) begin
		proc0 <= go && fire == 4'h0;
		proc1 <= go && fire == 4'h0;
		trig_src.comparator0 <= go && fire == 4'h1;
		trig_src.timer <= go && (fire == 4'h5 || fire == 4'h9);
		trig_src.timer_output_trigger_enable <= go && fire == 4'h5;
		trig_src.pwm_gen0 <= go && fire == 4'h6;
		trig_src.pwm_gen1 <= go && fire == 4'h7;
		trig_src.pwm_gen2 <= go && fire == 4'h8;
		hold <= {hold[0], go && fire == 4'h4};
		pin <= (go && fire == 4'h4) || (|hold);
	end
endmodule : trig_source_model

// ---- testbench/adc_trigger_select_test.sv ----
// Self-checking bench for the sequencer trigger selection block.
// Assumes the trigger source model drives all trigger inputs.
`timescale 1ns/10ps
module adc_trigger_select_test;
	import trig_sel_pkg::*;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic         go, pin, p0, p1, s0, s1, e;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, q;
	logic [3:0]   pstrb, fire;
	trig_src_type src;
	int           err_count, cmp_count, c1;
	logic [31:0]  n0, n1;
	adc_trigger_select i_adc_trigger_select (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .processor_start0(p0),
		.processor_start1(p1), .external_trigger_pin(pin), .trig_src(src),
		.sample_sequencer_zero_start(s0), .sample_sequencer_one_start(s1));
	trig_source_model i_trig_source_model (.pclk(pclk), .fire(fire), .go(go),
		.trig_src(src), .pin(pin), .proc0(p0), .proc1(p1));
	////////////////////////////////////////
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	task automatic end_of_test;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			$display("Error %0t: bus timeout", $time);
			end_of_test();
		end
		@(posedge pclk);
	endtask : apb
	function automatic int expect_cnt(input logic [3:0] c, input logic [3:0] f);
		return (c == SEL_ALWAYS) ? 10 : (c == f && f < 4'h9) ? 1 : 0;
	endfunction : expect_cnt
	task automatic trig(input logic [3:0] f, input logic [3:0] c0, input logic [3:0] cs);
		go <= 1'b1;
		fire <= f;
		@(posedge pclk);
		go <= 1'b0;
		n0 = 0;
		n1 = 0;
		repeat (10) begin
			@(posedge pclk);
			n0 = n0 + 32'(s0);
			n1 = n1 + 32'(s1);
		end
		chk(n0, expect_cnt(c0, f), "seq0 starts");
		chk(n1, expect_cnt(cs, f), "seq1 starts");
	endtask : trig
	////////////////////////////////////////
	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
		go = 0;
		fire = 0;
		err_count = 0;
		cmp_count = 0;
		void'($urandom(84));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, SEQ_TRIG_SEL_OFS, 32'h0);
		chk(q, SEQ_TRIG_SEL_RESET, "reset value");
		apb(1'b0, 12'hffc, 32'h0);
		chk(e, 32'h1, "unmapped error");
		chk(q, 32'h0, "unmapped read data");
		for (int f = 0; f < 10; f++) if (f != 2 && f != 3) for (int c = 0; c < 16; c++) begin
			c1 = (c == 15) ? f : (c == 14) ? 15 : $urandom % 16;
			pstrb <= 4'($urandom) | 4'h1;
			apb(1'b1, SEQ_TRIG_SEL_OFS, {24'($urandom), 4'(c1), 4'(c)});
			apb(1'b0, SEQ_TRIG_SEL_OFS, 32'h0);
			chk(q, {24'h0, 4'(c1), 4'(c)}, "field readback");
			trig(4'(f), 4'(c), 4'(c1));
		end
		pstrb <= 4'hf;
		apb(1'b1, SEQ_TRIG_SEL_OFS, 32'h0000_0056);
		pstrb <= 4'he;
		apb(1'b1, SEQ_TRIG_SEL_OFS, 32'h0000_0000);
		pstrb <= 4'hf;
		apb(1'b1, 12'hffc, 32'hffff_ffff);
		chk(e, 32'h1, "unmapped write error");
		apb(1'b0, SEQ_TRIG_SEL_OFS, 32'h0);
		chk(q, 32'h0000_0056, "ignored writes");
		apb(1'b1, SEQ_TRIG_SEL_OFS, 32'h0000_0000);
		apb(1'b1, TRIG_STATUS_OFS, 32'h0000_0003);
		apb(1'b0, TRIG_STATUS_OFS, 32'h0);
		chk(q, 32'h0, "status cleared");
		trig(4'h0, 4'h0, 4'h0);
		apb(1'b0, TRIG_STATUS_OFS, 32'h0);
		chk(q, 32'h3, "status set");
		apb(1'b1, TRIG_STATUS_OFS, 32'hffff_fffd);
		apb(1'b0, TRIG_STATUS_OFS, 32'h0);
		chk(q, 32'h2, "status bit zero cleared");
		apb(1'b1, SEQ_TRIG_SEL_OFS, 32'h0000_00ff);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(32'({s1, s0}), 32'h0, "starts after reset");
		apb(1'b0, SEQ_TRIG_SEL_OFS, 32'h0);
		chk(q, SEQ_TRIG_SEL_RESET, "reset value again");
		apb(1'b0, TRIG_STATUS_OFS, 32'h0);
		chk(q, 32'h0, "status after reset");
		end_of_test();
	end
endmodule : adc_trigger_select_test
